// file: prio_fwd_cfg_map.vh
// Register offsets, fields, reset values for the priority map and
// unknown-frame forwarding configuration. Definitions only.
// Assumes one register port in the switch system clock domain.
// How it works
// - bits 3:2 give priority for tag five
// - bits 1:0 give priority for tag four
// - two-queue mode maps results to low/high
// - result 0 low, result 3 high always
// - split bit0 steers result1, bit1 result2
// - split 00: results 0,1,2 low
// - split 10 default: 0,1 low, 2,3 high
// - split 11: only result 0 low
// - unicast enable bit 5, resets disabled
// - unicast map zero discards, resets zero
// - map bits 4:1 are per-port mask
// - map bit 0 reserved and ignored
// - multicast enable bit 5, resets disabled
// - multicast control only for non-IP frames
// - multicast map zero discards, resets zero
`ifndef PRIO_FWD_CFG_MAP_VH
`define PRIO_FWD_CFG_MAP_VH

// Register offsets
`define OFS_UPPER_TAG_MAP 8'h81
`define OFS_TWO_Q_SPLIT 8'h82
`define OFS_UNK_UNI_FWD 8'h83
`define OFS_UNK_MC_FWD 8'h84

// Field positions
`define TAG5_HI 3
`define TAG5_LO 2
`define TAG4_HI 1
`define TAG4_LO 0
`define SPLIT_HI 7
`define SPLIT_LO 6
`define FWD_EN_BIT 5
`define FWD_MAP_HI 4
`define FWD_MAP_LO 0
`define FWD_MASK_LO 1
`define DRIVE_HI 7
`define DRIVE_LO 6

// Reset values
`define RST_TAG5 2'h2
`define RST_TAG4 2'h2
`define RST_SPLIT 2'h2
`define RST_SPLIT_RSVD 6'h04
`define RST_FWD_EN 1'h0
`define RST_FWD_MAP 5'h00
`define RST_DRIVE 2'h1

// Tag codes handled here
`define PCP_FOUR 3'h4
`define PCP_FIVE 3'h5

`endif

// file: unknown_fwd_decode.v
// One unknown-frame forwarding decision, registered.
// Assumes enable and map come from the register bank, same clock.
`timescale 1ns/1ps
module unknown_fwd_decode #(
	parameter PORTS = 4
)(
	input wire core_clk,
	input wire rst,
	input wire lookReq,
	input wire fwdEnable,
	input wire [PORTS:0] portMap,
	output reg useMap_r,
	output reg drop_r,
	output reg [PORTS-1:0] portMask_r
);

	// Mask without the reserved low bit
	wire [PORTS-1:0] maskBits;
	assign maskBits = portMap[PORTS:1];

	// Decision held until the next lookup
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			useMap_r <= 1'b0;
			drop_r <= 1'b0;
			portMask_r <= {PORTS{1'b0}};
		end
		else if (lookReq)
		begin
			// Disabled map leaves the default path in charge
			useMap_r <= fwdEnable;
			drop_r <= fwdEnable & ~(|maskBits);
			portMask_r <= fwdEnable ? maskBits : {PORTS{1'b0}};
		end
	end

endmodule

// file: prio_fwd_cfg.v
// Priority map upper tags, two-queue split and unknown-frame
// forwarding configuration for the switch forwarding engine.
// Assumes register port and engine lookups share core_clk.
`timescale 1ns/1ps
`include "prio_fwd_cfg_map.vh"
module prio_fwd_cfg #(
	parameter PORTS = 4
)(
	input wire core_clk,
	input wire rst,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdData_r,
	output reg regRdValid_r,
	input wire pcpLook,
	input wire [2:0] pcpCode,
	output reg pcpHit_r,
	output reg [1:0] tagPriority_r,
	input wire queueLook,
	input wire twoQueueMode,
	input wire [1:0] prioResult,
	output reg queueValid_r,
	output reg queueHigh_r,
	input wire unkLook,
	input wire unkIsUnicast,
	input wire unkIsIp,
	output reg unkValid_r,
	output reg unkUseMap_r,
	output reg unkDrop_r,
	output reg [PORTS-1:0] unkPortMask_r
);

	// Stored fields
	reg [1:0] pcp_five_priority_r;
	reg [1:0] pcp_four_priority_r;
	reg [1:0] two_queue_split_select_r;
	reg uniEnable_r;
	reg [4:0] uniMap_r;
	reg mcEnable_r;
	reg [4:0] mcMap_r;
	reg [1:0] driveSel_r;

	// Address decode
	wire selTag;
	wire selSplit;
	wire selUni;
	wire selMc;
	assign selTag = (regAddr == `OFS_UPPER_TAG_MAP);
	assign selSplit = (regAddr == `OFS_TWO_Q_SPLIT);
	assign selUni = (regAddr == `OFS_UNK_UNI_FWD);
	assign selMc = (regAddr == `OFS_UNK_MC_FWD);

	// Writable fields; read-only bits are simply not stored
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			pcp_five_priority_r <= `RST_TAG5;
			pcp_four_priority_r <= `RST_TAG4;
			two_queue_split_select_r <= `RST_SPLIT;
			uniEnable_r <= `RST_FWD_EN;
			uniMap_r <= `RST_FWD_MAP;
			mcEnable_r <= `RST_FWD_EN;
			mcMap_r <= `RST_FWD_MAP;
			driveSel_r <= `RST_DRIVE;
		end
		else if (regWr)
		begin
			if (selTag)
			begin
				pcp_five_priority_r <= regWrData[`TAG5_HI:`TAG5_LO];
				pcp_four_priority_r <= regWrData[`TAG4_HI:`TAG4_LO];
			end
			// Value 01 is accepted as written; decode stays bitwise
			if (selSplit)
				two_queue_split_select_r <= regWrData[`SPLIT_HI:`SPLIT_LO];
			if (selUni)
			begin
				uniEnable_r <= regWrData[`FWD_EN_BIT];
				uniMap_r <= regWrData[`FWD_MAP_HI:`FWD_MAP_LO];
			end
			if (selMc)
			begin
				driveSel_r <= regWrData[`DRIVE_HI:`DRIVE_LO];
				mcEnable_r <= regWrData[`FWD_EN_BIT];
				mcMap_r <= regWrData[`FWD_MAP_HI:`FWD_MAP_LO];
			end
		end
	end

	// Read mux; reserved bits show fixed reset values
	reg [7:0] rdMux;
	always @*
	begin
		rdMux = 8'h00;
		if (selTag)
			rdMux = {4'h0, pcp_five_priority_r, pcp_four_priority_r};
		else if (selSplit)
			rdMux = {two_queue_split_select_r, `RST_SPLIT_RSVD};
		else if (selUni)
			rdMux = {2'h0, uniEnable_r, uniMap_r};
		else if (selMc)
			rdMux = {driveSel_r, mcEnable_r, mcMap_r};
	end

	// Read data registered; unmapped offsets answer zero
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			regRdData_r <= 8'h00;
			regRdValid_r <= 1'b0;
		end
		else
		begin
			regRdValid_r <= regRd;
			if (regRd)
				regRdData_r <= rdMux;
		end
	end

	// Tag lookup; only codes four and five are answered here
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			pcpHit_r <= 1'b0;
			tagPriority_r <= 2'h0;
		end
		else
		begin
			pcpHit_r <= 1'b0;
			if (pcpLook)
			begin
				if (pcpCode == `PCP_FIVE)
				begin
					pcpHit_r <= 1'b1;
					tagPriority_r <= pcp_five_priority_r;
				end
				else if (pcpCode == `PCP_FOUR)
				begin
					pcpHit_r <= 1'b1;
					tagPriority_r <= pcp_four_priority_r;
				end
			end
		end
	end

	// Two-queue split; bitwise so every split value is defined
	reg queueHigh_nxt;
	always @*
	begin
		case (prioResult)
			2'h0: queueHigh_nxt = 1'b0;
			2'h1: queueHigh_nxt = two_queue_split_select_r[0];
			2'h2: queueHigh_nxt = two_queue_split_select_r[1];
			2'h3: queueHigh_nxt = 1'b1;
			default: queueHigh_nxt = 1'b0;
		endcase
	end

	// Queue answer only in two-queue mode
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			queueValid_r <= 1'b0;
			queueHigh_r <= 1'b0;
		end
		else
		begin
			queueValid_r <= queueLook & twoQueueMode;
			if (queueLook & twoQueueMode)
				queueHigh_r <= queueHigh_nxt;
		end
	end

	// IP multicast bypasses the multicast control entirely
	wire uniReq;
	wire mcReq;
	assign uniReq = unkLook & unkIsUnicast;
	assign mcReq = unkLook & ~unkIsUnicast & ~unkIsIp;

	wire uniUse;
	wire uniDrop;
	wire [PORTS-1:0] uniMask;
	wire mcUse;
	wire mcDrop;
	wire [PORTS-1:0] mcMask;

	unknown_fwd_decode #(.PORTS(PORTS)) uniDec (
		.core_clk(core_clk),
		.rst(rst),
		.lookReq(uniReq),
		.fwdEnable(uniEnable_r),
		.portMap(uniMap_r[PORTS:0]),
		.useMap_r(uniUse),
		.drop_r(uniDrop),
		.portMask_r(uniMask)
	);

	unknown_fwd_decode #(.PORTS(PORTS)) mcDec (
		.core_clk(core_clk),
		.rst(rst),
		.lookReq(mcReq),
		.fwdEnable(mcEnable_r),
		.portMap(mcMap_r[PORTS:0]),
		.useMap_r(mcUse),
		.drop_r(mcDrop),
		.portMask_r(mcMask)
	);

	// Remember which decoder answers; IP multicast frames get no answer
	reg uniSel_r;
	reg mcSel_r;
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			uniSel_r <= 1'b0;
			mcSel_r <= 1'b0;
		end
		else
		begin
			uniSel_r <= uniReq;
			mcSel_r <= mcReq;
		end
	end

	// Final registered answer, one cycle behind the decoders
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			unkValid_r <= 1'b0;
			unkUseMap_r <= 1'b0;
			unkDrop_r <= 1'b0;
			unkPortMask_r <= {PORTS{1'b0}};
		end
		else
		begin
			unkValid_r <= uniSel_r | mcSel_r;
			if (uniSel_r)
			begin
				unkUseMap_r <= uniUse;
				unkDrop_r <= uniDrop;
				unkPortMask_r <= uniMask;
			end
			else if (mcSel_r)
			begin
				unkUseMap_r <= mcUse;
				unkDrop_r <= mcDrop;
				unkPortMask_r <= mcMask;
			end
			else if (unkValid_r)
			begin
				unkUseMap_r <= 1'b0;
				unkDrop_r <= 1'b0;
				unkPortMask_r <= {PORTS{1'b0}};
			end
		end
	end

endmodule

// file: prio_fwd_cfg_sva.sv
// Checker for prio_fwd_cfg answer timing and decodes.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module prio_fwd_cfg_sva #(parameter PORTS = 4)(
	input wire core_clk,
	input wire rst,
	input wire regRd,
	input wire regRdValid_r,
	input wire pcpLook,
	input wire pcpHit_r,
	input wire queueLook,
	input wire twoQueueMode,
	input wire [2:0] pcpCode,
	input wire [1:0] prioResult,
	input wire queueValid_r,
	input wire queueHigh_r,
	input wire unkLook,
	input wire unkIsUnicast,
	input wire unkIsIp,
	input wire unkValid_r,
	input wire unkUseMap_r,
	input wire unkDrop_r,
	input wire [PORTS-1:0] unkPortMask_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Accepted requests; IP multicast never counts
	wire qReq = queueLook && twoQueueMode;
	wire uReq = unkLook && (unkIsUnicast || !unkIsIp);
	wire tHit = pcpLook && pcpCode[2:1] == 2'h2;
	sequence sUnkReq;
		uReq;
	endsequence
	sequence sUnkAns;
		##2 unkValid_r;
	endsequence
	a_rd_valid: assert property (regRdValid_r == $past(regRd))
		else $error("read answer timing wrong");
	a_pcp_hit: assert property (pcpHit_r == $past(tHit))
		else $error("tag hit wrong");
	a_q_valid: assert property (queueValid_r == $past(qReq))
		else $error("queue answer wrong");
	a_q_low: assert property (qReq && prioResult == 2'h0 |=>
		!queueHigh_r) else $error("result 0 not low");
	a_q_high: assert property (qReq && prioResult == 2'h3 |=>
		queueHigh_r) else $error("result 3 not high");
	a_unk_lat: assert property (sUnkReq |-> sUnkAns)
		else $error("unknown answer late");
	a_unk_only: assert property (unkValid_r == $past(uReq, 2))
		else $error("unknown answer spurious");
	a_drop_empty: assert property (unkValid_r |->
		unkDrop_r == (unkUseMap_r && unkPortMask_r == 0))
		else $error("drop decode wrong");
	a_default_fwd: assert property (unkValid_r && !unkUseMap_r |->
		!unkDrop_r && unkPortMask_r == 0) else $error("map used");
endmodule

bind prio_fwd_cfg prio_fwd_cfg_sva #(.PORTS(PORTS)) i_sva (.core_clk,
	.rst, .regRd, .regRdValid_r, .pcpLook, .pcpHit_r, .queueLook,
	.twoQueueMode, .pcpCode, .prioResult, .queueValid_r, .queueHigh_r,
	.unkLook, .unkIsUnicast, .unkIsIp, .unkValid_r, .unkUseMap_r,
	.unkDrop_r, .unkPortMask_r);

// file: prio_fwd_cfg_bench.sv
// Bench for prio_fwd_cfg: register port and the three lookups.
// Assumes default PORTS; checker is bound from its own file.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
	n_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module prio_fwd_cfg_bench;
	logic core_clk = 0, rst = 1, regWr = 0, regRd = 0, pcpLook = 0;
	logic queueLook = 0, twoQueueMode = 0, unkLook = 0;
	logic unkIsUnicast = 0, unkIsIp = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
	logic [2:0] pcpCode = 3'h0;
	logic [1:0] prioResult = 2'h0, s;
	logic qh;
	wire [7:0] regRdData_r;
	wire regRdValid_r, pcpHit_r, queueValid_r, queueHigh_r;
	wire unkValid_r, unkUseMap_r, unkDrop_r;
	wire [1:0] tagPriority_r;
	wire [3:0] unkPortMask_r;
	int n_errors = 0, n_checks = 0, cyc = 0;
	prio_fwd_cfg i_prio_fwd_cfg (.core_clk, .rst, .regAddr, .regWrData,
		.regWr, .regRd, .regRdData_r, .regRdValid_r, .pcpLook, .pcpCode,
		.pcpHit_r, .tagPriority_r, .queueLook, .twoQueueMode,
		.prioResult, .queueValid_r, .queueHigh_r, .unkLook,
		.unkIsUnicast, .unkIsIp, .unkValid_r, .unkUseMap_r, .unkDrop_r,
		.unkPortMask_r);
	// 50 ns clock
	initial
	begin
		forever #25 core_clk = ~core_clk;
	end
	// Hang guard, far above the 113 or so cycles needed
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_errors++;
			results;
		end
	end
	task results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Inputs move 1 ns after the edge, clear of sampling
	task step;
		@(posedge core_clk);
		#1;
	endtask
	task wr(input [7:0] a, d);
		step;
		regAddr = a;
		regWrData = d;
		regWr = 1;
		step;
		regWr = 0;
	endtask
	task rd(input [7:0] a, e);
		step;
		regAddr = a;
		regRd = 1;
		step;
		regRd = 0;
		`CHK("rvalid", 1'b1, regRdValid_r)
		`CHK("rdata", e, regRdData_r)
	endtask
	task tg(input [2:0] c, input h, input [1:0] p);
		step;
		pcpCode = c;
		pcpLook = 1;
		step;
		pcpLook = 0;
		`CHK("hit", h, pcpHit_r)
		if (h)
			`CHK("prio", p, tagPriority_r)
	endtask
	task qm(input m, input [1:0] r, input h);
		step;
		twoQueueMode = m;
		prioResult = r;
		queueLook = 1;
		step;
		queueLook = 0;
		`CHK("qvalid", m, queueValid_r)
		if (m)
			`CHK("qhigh", h, queueHigh_r)
	endtask
	task uk(input u, ip, v, um, dr, input [3:0] mk);
		step;
		unkIsUnicast = u;
		unkIsIp = ip;
		unkLook = 1;
		step;
		unkLook = 0;
		step;
		`CHK("uvalid", v, unkValid_r)
		if (v)
		begin
			`CHK("usemap", um, unkUseMap_r)
			`CHK("udrop", dr, unkDrop_r)
			`CHK("umask", mk, unkPortMask_r)
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge core_clk);
		#1 rst = 0;
		rd(8'h81, 8'h0a);
		rd(8'h82, 8'h84);
		rd(8'h83, 8'h00);
		rd(8'h84, 8'h40);
		rd(8'h85, 8'h00);
		tg(3'h5, 1'b1, 2'h2);
		tg(3'h3, 1'b0, 2'h0);
		qm(1'b1, 2'h2, 1'b1);
		qm(1'b0, 2'h3, 1'b0);
		wr(8'h81, 8'hf6);
		rd(8'h81, 8'h06);
		tg(3'h5, 1'b1, 2'h1);
		tg(3'h4, 1'b1, 2'h2);
		// Split 01 is never written
		for (int i = 0; i < 4; i++)
		begin
			s = 2'(i);
			if (i != 1)
			begin
				wr(8'h82, {s, 6'h3b});
				rd(8'h82, {s, 6'h04});
				for (int j = 0; j < 4; j++)
				begin
					qh = (j == 3) || (j == 1 && s[0]) || (j == 2 && s[1]);
					qm(1'b1, 2'(j), qh);
				end
			end
		end
		wr(8'h83, 8'hff);
		rd(8'h83, 8'h3f);
		uk(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf);
		wr(8'h83, 8'h21);
		uk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
		wr(8'h83, 8'h06);
		uk(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
		wr(8'h84, 8'h27);
		uk(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h3);
		uk(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
		wr(8'h84, 8'h60);
		uk(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
		// Reset in mid-run brings the split and both forwarding defaults back
		step;
		rst = 1'b1;
		repeat (2) step;
		rst = 1'b0;
		rd(8'h82, 8'h84);
		rd(8'h83, 8'h00);
		rd(8'h84, 8'h40);
		results;
	end
endmodule
